// >>> rtl/isr_pkg.sv
// Purpose: shared constants and carriers of the indirect store and return unit
// Assumes: byte addressed classic Wishbone, one aligned word per register
// Notes: all offsets below are byte addresses
package isr_pkg;
  localparam int PTR_W = 16;
  localparam int ACC_W = 8;
  localparam int PC_W = 15;
  localparam int OFS_W = 6;
  localparam int NUM_PTR = 2;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;

  // register byte addresses
  localparam logic [7:0] ADR_PTR0 = 8'h00;
  localparam logic [7:0] ADR_PTR1 = 8'h04;
  localparam logic [7:0] ADR_OPTION = 8'h08;
  localparam logic [7:0] ADR_PWRCTL = 8'h0C;
  localparam logic [7:0] ADR_INTCTL = 8'h10;
  localparam logic [7:0] ADR_STATE = 8'h14;

  // field positions
  localparam int SWRST_BIT = 0;
  localparam int PERMIT_BIT = 7;
  localparam int BUSY_BIT = 0;

  // reset values
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic SWRST_RST = 1'b1;
  localparam logic PERMIT_RST = 1'b0;

  localparam logic [15:0] PTR_ONE = 16'h0001;

  // pointer adjust codes
  localparam logic [1:0] ADJ_PREINC = 2'h0;
  localparam logic [1:0] ADJ_PREDEC = 2'h1;
  localparam logic [1:0] ADJ_POSTINC = 2'h2;
  localparam logic [1:0] ADJ_POSTDEC = 2'h3;
  localparam int ADJ_DEC_BIT = 0;
  localparam int ADJ_POST_BIT = 1;

  typedef enum logic [1:0] {
    ISR_OP_STORE,
    ISR_OP_OPTION,
    ISR_OP_SWRESET,
    ISR_OP_RETINT
  } isr_op_e;

  typedef enum logic {
    ISR_ST_IDLE,
    ISR_ST_RET2
  } isr_state_e;

  typedef struct packed {
    isr_op_e op;
    logic ptrSel;
    logic [1:0] adjCode;
    logic relForm;
    logic [OFS_W-1:0] offset;
  } isr_instr_s;

  typedef struct packed {
    logic we;
    logic [PTR_W-1:0] addr;
    logic [ACC_W-1:0] data;
  } isr_memwr_s;

  typedef struct packed {
    logic pop;
    logic load;
    logic [PC_W-1:0] value;
  } isr_pcload_s;
endpackage : isr_pkg

// >>> rtl/isr_unit.sv
// Purpose: executes indirect store, option load, software reset, interrupt return
// Assumes: one instruction offered per cycle with insValid, taken when insReady
// Notes: registers reachable over classic Wishbone, one wait state per access
//
// Our own choices: the Wishbone register port and the address map.
module isr_unit (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [isr_pkg::ADR_W-1:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [isr_pkg::DAT_W-1:0] wbDatW,
  output logic [isr_pkg::DAT_W-1:0] wbDatR,
  output logic wbAck,
  // instruction issue
  input wire logic insValid,
  input wire isr_pkg::isr_instr_s insData,
  input wire logic [isr_pkg::ACC_W-1:0] accValue,
  input wire logic [isr_pkg::PC_W-1:0] stackTopValue,
  output logic insReady,
  // execution results
  output isr_pkg::isr_memwr_s memWr,
  output isr_pkg::isr_pcload_s retCtl,
  output logic swResetReq,
  output logic [isr_pkg::ACC_W-1:0] optionValue,
  output logic swResetFlag,
  output logic permitState
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [isr_pkg::NUM_PTR-1:0][isr_pkg::PTR_W-1:0] ptr_q, ptr_d;
  logic [isr_pkg::ACC_W-1:0] option_q, option_d;
  logic swFlag_q, swFlag_d;
  logic permit_q, permit_d;
  logic swReq_q, swReq_d;
  isr_pkg::isr_state_e state_q, state_d;
  isr_pkg::isr_memwr_s memWr_q, memWr_d;
  isr_pkg::isr_pcload_s ret_q, ret_d;
  logic ack_q, ack_d;
  logic [isr_pkg::DAT_W-1:0] rdat_q, rdat_d;

  logic busHit;
  logic busWrite;
  logic [isr_pkg::DAT_W-1:0] wrWord;
  logic [isr_pkg::DAT_W-1:0] ptrWord0;
  logic [isr_pkg::DAT_W-1:0] ptrWord1;
  logic issue;
  logic [isr_pkg::PTR_W-1:0] selPtr;
  logic [isr_pkg::PTR_W-1:0] sextOfs;
  logic [isr_pkg::PTR_W-1:0] ptrStep;
  logic [isr_pkg::PTR_W-1:0] effAddr;
  logic [isr_pkg::PTR_W-1:0] ptrNext;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave
  assign busHit = wbCyc & wbStb;
  // write lands on the edge where the master sees ack
  assign busWrite = busHit & wbWe & ack_q;

  // byte lanes merge onto a zero-extended copy of the old value
  function automatic logic [31:0] mergeSel(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  always_comb begin
    ack_d = busHit & ~ack_q;
    rdat_d = '0;
    if (busHit & ~ack_q & ~wbWe) begin
      case (wbAdr)
        isr_pkg::ADR_PTR0: rdat_d[isr_pkg::PTR_W-1:0] = ptr_q[0];
        isr_pkg::ADR_PTR1: rdat_d[isr_pkg::PTR_W-1:0] = ptr_q[1];
        isr_pkg::ADR_OPTION: rdat_d[isr_pkg::ACC_W-1:0] = option_q;
        isr_pkg::ADR_PWRCTL: rdat_d[isr_pkg::SWRST_BIT] = swFlag_q;
        isr_pkg::ADR_INTCTL: rdat_d[isr_pkg::PERMIT_BIT] = permit_q;
        isr_pkg::ADR_STATE: rdat_d[isr_pkg::BUSY_BIT] = (state_q != isr_pkg::ISR_ST_IDLE);
        default: rdat_d = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wbAck = ack_q;
  assign wbDatR = rdat_q;

  ////////////////////////////////////////////////////////////////////////////
  // address arithmetic
  assign issue = insValid & insReady;
  assign selPtr = ptr_q[insData.ptrSel];
  assign sextOfs = {{(isr_pkg::PTR_W-isr_pkg::OFS_W){insData.offset[isr_pkg::OFS_W-1]}},
                    insData.offset};

  assign ptrStep = insData.adjCode[isr_pkg::ADJ_DEC_BIT] ? (selPtr - isr_pkg::PTR_ONE)
                                                         : (selPtr + isr_pkg::PTR_ONE);

  always_comb begin
    if (insData.relForm) begin
      effAddr = selPtr + sextOfs;
      ptrNext = selPtr;
    end else begin
      effAddr = insData.adjCode[isr_pkg::ADJ_POST_BIT] ? selPtr : ptrStep;
      ptrNext = ptrStep;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // execution
  assign insReady = (state_q == isr_pkg::ISR_ST_IDLE);

  always_comb begin
    ptr_d = ptr_q;
    option_d = option_q;
    swFlag_d = swFlag_q;
    permit_d = permit_q;
    swReq_d = 1'b0;
    state_d = state_q;
    memWr_d = memWr_q;
    memWr_d.we = 1'b0;
    ret_d = ret_q;
    ret_d.pop = 1'b0;
    ret_d.load = 1'b0;
    wrWord = mergeSel('0, wbDatW, wbSel);
    // a call result cannot be sliced, so merge into a full word first
    ptrWord0 = mergeSel({16'h0000, ptr_q[0]}, wbDatW, wbSel);
    ptrWord1 = mergeSel({16'h0000, ptr_q[1]}, wbDatW, wbSel);
    // software writes first, an executing instruction overrides them
    if (busWrite) begin
      case (wbAdr)
        isr_pkg::ADR_PTR0: ptr_d[0] = ptrWord0[isr_pkg::PTR_W-1:0];
        isr_pkg::ADR_PTR1: ptr_d[1] = ptrWord1[isr_pkg::PTR_W-1:0];
        isr_pkg::ADR_OPTION: if (wbSel[0]) option_d = wrWord[isr_pkg::ACC_W-1:0];
        isr_pkg::ADR_PWRCTL: if (wbSel[0]) swFlag_d = wrWord[isr_pkg::SWRST_BIT];
        isr_pkg::ADR_INTCTL: if (wbSel[0]) permit_d = wrWord[isr_pkg::PERMIT_BIT];
        default: ;
      endcase
    end
    case (state_q)
      isr_pkg::ISR_ST_IDLE: begin
        if (insValid) begin
          case (insData.op)
            isr_pkg::ISR_OP_STORE: begin
              memWr_d.we = 1'b1;
              memWr_d.addr = effAddr;
              memWr_d.data = accValue;
              ptr_d[insData.ptrSel] = ptrNext;
            end
            isr_pkg::ISR_OP_OPTION: begin
              option_d = accValue;
            end
            isr_pkg::ISR_OP_SWRESET: begin
              swReq_d = 1'b1;
              swFlag_d = 1'b0;
            end
            isr_pkg::ISR_OP_RETINT: begin
              ret_d.pop = 1'b1;
              ret_d.value = stackTopValue;
              state_d = isr_pkg::ISR_ST_RET2;
              permit_d = 1'b1;
            end
            default: ;
          endcase
        end
      end
      isr_pkg::ISR_ST_RET2: begin
        ret_d.load = 1'b1;
        state_d = isr_pkg::ISR_ST_IDLE;
      end
      default: state_d = isr_pkg::ISR_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_q <= {isr_pkg::PTR_RST, isr_pkg::PTR_RST};
      option_q <= isr_pkg::OPTION_RST;
      swFlag_q <= isr_pkg::SWRST_RST;
      permit_q <= isr_pkg::PERMIT_RST;
      swReq_q <= 1'b0;
      state_q <= isr_pkg::ISR_ST_IDLE;
      memWr_q <= '0;
      ret_q <= '0;
    end else begin
      ptr_q <= ptr_d;
      option_q <= option_d;
      swFlag_q <= swFlag_d;
      permit_q <= permit_d;
      swReq_q <= swReq_d;
      state_q <= state_d;
      memWr_q <= memWr_d;
      ret_q <= ret_d;
    end
  end

  assign memWr = memWr_q;
  assign retCtl = ret_q;
  assign swResetReq = swReq_q;
  assign optionValue = option_q;
  assign swResetFlag = swFlag_q;
  assign permitState = permit_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  logic isStore;
  assign isStore = issue & (insData.op == isr_pkg::ISR_OP_STORE);

  property p_store_data;
    @(posedge ref_clk) disable iff (!arst_n)
      isStore |=> memWr_q.we && (memWr_q.data == $past(accValue));
  endproperty
  a_store_data: assert property (p_store_data) else $error("store data wrong");

  property p_pre_inc;
    @(posedge ref_clk) disable iff (!arst_n)
      isStore && !insData.relForm && (insData.adjCode == isr_pkg::ADJ_PREINC)
      |=> memWr_q.addr == $past(selPtr) + 16'h0001;
  endproperty
  a_pre_inc: assert property (p_pre_inc) else $error("preincrement address wrong");

  property p_post_dec;
    @(posedge ref_clk) disable iff (!arst_n)
      isStore && !insData.relForm && (insData.adjCode == isr_pkg::ADJ_POSTDEC)
      |=> (memWr_q.addr == $past(selPtr))
          && (ptr_q[$past(insData.ptrSel)] == $past(selPtr) - 16'h0001);
  endproperty
  a_post_dec: assert property (p_post_dec) else $error("postdecrement wrong");

  property p_rel;
    @(posedge ref_clk) disable iff (!arst_n)
      isStore && insData.relForm
      |=> (memWr_q.addr == $past(selPtr) + $past(sextOfs))
          && (ptr_q[$past(insData.ptrSel)] == $past(selPtr));
  endproperty
  a_rel: assert property (p_rel) else $error("relative store wrong");

  property p_wrap;
    @(posedge ref_clk) disable iff (!arst_n)
      isStore && !insData.relForm && (insData.adjCode == isr_pkg::ADJ_POSTINC)
      && (selPtr == 16'hFFFF) |=> ptr_q[$past(insData.ptrSel)] == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

  property p_option;
    @(posedge ref_clk) disable iff (!arst_n)
      issue && (insData.op == isr_pkg::ISR_OP_OPTION)
      |=> (optionValue == $past(accValue)) && insReady;
  endproperty
  a_option: assert property (p_option) else $error("option load wrong");

  property p_swreset;
    @(posedge ref_clk) disable iff (!arst_n)
      issue && (insData.op == isr_pkg::ISR_OP_SWRESET) |=> swResetReq && !swResetFlag
      ##1 (swResetReq == $past(issue && (insData.op == isr_pkg::ISR_OP_SWRESET)));
  endproperty
  a_swreset: assert property (p_swreset) else $error("software reset wrong");

  property p_retint;
    @(posedge ref_clk) disable iff (!arst_n)
      issue && (insData.op == isr_pkg::ISR_OP_RETINT)
      |=> retCtl.pop && !insReady
      ##1 retCtl.load && (retCtl.value == $past(stackTopValue, 2));
  endproperty
  a_retint: assert property (p_retint) else $error("interrupt return wrong");

  // software may clear the permit again during the second cycle
  property p_permit;
    @(posedge ref_clk) disable iff (!arst_n)
      issue && (insData.op == isr_pkg::ISR_OP_RETINT)
      |=> permitState ##1 (permitState || $past(busWrite && (wbAdr == isr_pkg::ADR_INTCTL)));
  endproperty
  a_permit: assert property (p_permit) else $error("permit bit not set");

  property p_no_flags;
    @(posedge ref_clk) disable iff (!arst_n)
      isStore && !busWrite
      |=> $stable(swResetFlag) && $stable(permitState) && $stable(optionValue);
  endproperty
  a_no_flags: assert property (p_no_flags) else $error("store changed a flag");

  property p_single;
    @(posedge ref_clk) disable iff (!arst_n)
      isStore |=> insReady;
  endproperty
  a_single: assert property (p_single) else $error("store not single cycle");

  c_store: cover property (@(posedge ref_clk) disable iff (!arst_n) isStore ##1 isStore);
  c_retint: cover property (@(posedge ref_clk) disable iff (!arst_n) retCtl.load);
  c_swreset: cover property (@(posedge ref_clk) disable iff (!arst_n) swResetReq);
  c_buswr: cover property (@(posedge ref_clk) disable iff (!arst_n) busWrite);

endmodule // isr_unit

// >>> verif/tb.sv
// Purpose: self-checking bench for the indirect store and return unit
// Assumes: one wait state on the register bus, results one cycle after issue
// Notes: pointers are preset over the bus so wrap cases start at the edges
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, arst_n, wbCyc, wbStb, wbWe, wbAck, insValid, insReady;
  logic swResetReq, swResetFlag, permitState;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatW, wbDatR;
  isr_pkg::isr_instr_s insData;
  logic [7:0] accValue, optionValue;
  logic [14:0] stackTopValue;
  isr_pkg::isr_memwr_s memWr;
  isr_pkg::isr_pcload_s retCtl;
  int errTotal, totalChecks;
  logic [15:0] ptrModel [2];

  isr_unit DUT (.ref_clk(ref_clk), .arst_n(arst_n), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR),
    .wbAck(wbAck), .insValid(insValid), .insData(insData), .accValue(accValue),
    .stackTopValue(stackTopValue), .insReady(insReady), .memWr(memWr), .retCtl(retCtl),
    .swResetReq(swResetReq), .optionValue(optionValue),
    .swResetFlag(swResetFlag), .permitState(permitState));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // master holds everything until ack is sampled high; only the watchdog ends a wait
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    output logic [31:0] rd);
    @(posedge ref_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatW <= dat;
    wbSel <= 4'hF;
    do begin
      @(posedge ref_clk);
    end while (wbAck !== 1'b1);
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    // ack stands for one cycle only
    @(posedge ref_clk);
    chk("wbAck drop", {31'h0, wbAck}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] rd;
    wb(1'b1, adr, dat, rd);
  endtask

  task automatic rdchk(input string name, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] rd;
    wb(1'b0, adr, 32'h0, rd);
    chk(name, rd, exp);
  endtask

  // issue one instruction; returns just after the edge that took it
  task automatic ins(input isr_pkg::isr_op_e op, input logic sel, input logic [1:0] adj,
                     input logic rel, input logic [5:0] ofs, input logic [7:0] acc);
    @(posedge ref_clk);
    insValid <= 1'b1;
    insData.op <= op;
    insData.ptrSel <= sel;
    insData.adjCode <= adj;
    insData.relForm <= rel;
    insData.offset <= ofs;
    accValue <= acc;
    stackTopValue <= 15'h1234;
    @(posedge ref_clk);
    chk("insReady", {31'h0, insReady}, 32'h1);
    insValid <= 1'b0;
    #1;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    chk("option", {24'h0, optionValue}, 32'hFF);
    rdchk("ptr0", isr_pkg::ADR_PTR0, 32'h0);
    rdchk("pwrctl", isr_pkg::ADR_PWRCTL, 32'h1);
    rdchk("intctl", isr_pkg::ADR_INTCTL, 32'h0);
    // unmapped and read-only places ignore writes
    wr(8'h20, 32'hFFFF_FFFF);
    rdchk("unmapped", 8'h20, 32'h0);
    wr(isr_pkg::ADR_STATE, 32'h1);
    rdchk("state", isr_pkg::ADR_STATE, 32'h0);
    $display("test reset done");
  endtask

  task automatic test_store;
    logic [15:0] np, ea;
    for (int s = 0; s < 2; s++) begin
      for (int a = 0; a < 4; a++) begin
        ptrModel[s] = a[0] ? 16'h0000 : 16'hFFFF;
        wr(s ? isr_pkg::ADR_PTR1 : isr_pkg::ADR_PTR0, {16'h0, ptrModel[s]});
        np = a[0] ? ptrModel[s] - 16'h1 : ptrModel[s] + 16'h1;
        ea = a[1] ? ptrModel[s] : np;
        ins(isr_pkg::ISR_OP_STORE, s[0], a[1:0], 1'b0, 6'h00, 8'hA0 + 8'(a));
        chk("we", {31'h0, memWr.we}, 32'h1);
        chk("addr", {16'h0, memWr.addr}, {16'h0, ea});
        chk("data", {24'h0, memWr.data}, 32'hA0 + a);
        chk("ready", {31'h0, insReady}, 32'h1);
        ptrModel[s] = np;
        rdchk("ptr", s ? 8'h04 : 8'h00, {16'h0, np});
        chk("we drop", {31'h0, memWr.we}, 32'h0);
        chk("permit", {31'h0, permitState}, 32'h0);
        chk("swflag kept", {31'h0, swResetFlag}, 32'h1);
        chk("option kept", {24'h0, optionValue}, 32'hFF);
      end
    end
    $display("test store done");
  endtask

  task automatic test_rel;
    logic [5:0] ofs;
    for (int k = 0; k < 2; k++) begin
      ofs = k ? 6'h1F : 6'h20;
      wr(k ? isr_pkg::ADR_PTR1 : isr_pkg::ADR_PTR0, 32'h0100);
      ins(isr_pkg::ISR_OP_STORE, k[0], 2'h0, 1'b1, ofs, 8'h5C);
      chk("rel addr", {16'h0, memWr.addr}, k ? 32'h011F : 32'h00E0);
      chk("rel data", {24'h0, memWr.data}, 32'h5C);
      rdchk("rel ptr", k ? 8'h04 : 8'h00, 32'h0100);
    end
    $display("test rel done");
  endtask

  task automatic test_ops;
    ins(isr_pkg::ISR_OP_OPTION, 1'b0, 2'h0, 1'b0, 6'h00, 8'h4F);
    chk("option", {24'h0, optionValue}, 32'h4F);
    chk("no store", {31'h0, memWr.we}, 32'h0);
    chk("option ready", {31'h0, insReady}, 32'h1);
    rdchk("option rd", isr_pkg::ADR_OPTION, 32'h4F);
    ins(isr_pkg::ISR_OP_SWRESET, 1'b0, 2'h0, 1'b0, 6'h00, 8'h00);
    chk("swreq", {31'h0, swResetReq}, 32'h1);
    chk("swflag", {31'h0, swResetFlag}, 32'h0);
    rdchk("pwrctl", isr_pkg::ADR_PWRCTL, 32'h0);
    chk("swreq drop", {31'h0, swResetReq}, 32'h0);
    wr(isr_pkg::ADR_INTCTL, 32'h0);
    ins(isr_pkg::ISR_OP_RETINT, 1'b0, 2'h0, 1'b0, 6'h00, 8'h00);
    chk("pop", {31'h0, retCtl.pop}, 32'h1);
    chk("early load", {31'h0, retCtl.load}, 32'h0);
    chk("permit", {31'h0, permitState}, 32'h1);
    chk("busy", {31'h0, insReady}, 32'h0);
    @(posedge ref_clk);
    #1;
    chk("load", {31'h0, retCtl.load}, 32'h1);
    chk("pop drop", {31'h0, retCtl.pop}, 32'h0);
    chk("pc", {17'h0, retCtl.value}, 32'h1234);
    chk("ready again", {31'h0, insReady}, 32'h1);
    rdchk("intctl", isr_pkg::ADR_INTCTL, 32'h80);
    $display("test ops done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    errTotal++;
    close_out();
  end

  initial begin
    arst_n = 1'b0;
    {wbCyc, wbStb, wbWe, insValid} = 4'h0;
    wbAdr = 8'h00;
    wbSel = 4'h0;
    wbDatW = 32'h0;
    insData = '0;
    accValue = 8'h00;
    stackTopValue = 15'h0000;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    test_reset();
    test_store();
    test_rel();
    test_ops();
    close_out();
  end
endmodule // tb
